// ---- src/bcdc_core.sv ----
`timescale 1ns/1ps
module bcdc_core
  import bcdc_pkg::*;
(
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_N_I,
  input  wire logic                   CE_I,
  input  wire logic                   OP_VALID_I,
  input  bcdc_op_e                    OP_CODE_I,
  input  wire logic [BCDC_DATA_W-1:0] OPERAND_I,
  input  wire logic                   RD_STB_I,
  output logic      [BCDC_DATA_W-1:0] ACC_O,
  output logic                        CARRY_FLAG_O,
  output logic                        AUX_CARRY_FLAG_O,
  output logic      [BCDC_DATA_W-1:0] RD_DATA_O,
  output logic                        RD_VALID_O
);

  // ==========================================================================
  // Live correction value
  // ==========================================================================
  logic [BCDC_DATA_W-1:0] acc_r;
  logic [BCDC_DATA_W-1:0] acc_nxt;
  logic                   carry_flag_r;
  logic                   carry_flag_nxt;
  logic                   aux_carry_flag_r;
  logic                   aux_carry_flag_nxt;
  logic [BCDC_DATA_W-1:0] bcd_correction_value;
  logic                   fix_hi_carry;

  // A low nibble past 9 under a high nibble of 9 overflows into it once fixed
  assign fix_hi_carry = carry_flag_r                                          // RULE8
    || ((acc_r[BCDC_DATA_W-1:BCDC_NIB_W] == BCDC_NIB_MAX)
    && (acc_r[BCDC_NIB_W-1:0] > BCDC_NIB_MAX));

  // Purely combinational so that a read always reflects the present state
  bcdc_nibble_fix u_fix_lo (                                                  // RULE5
    .nib_i   (acc_r[BCDC_NIB_W-1:0]),
    .carry_i (aux_carry_flag_r),
    .fix_o   (bcd_correction_value[BCDC_NIB_W-1:0])
  );

  bcdc_nibble_fix u_fix_hi (
    .nib_i   (acc_r[BCDC_DATA_W-1:BCDC_NIB_W]),
    .carry_i (fix_hi_carry),
    .fix_o   (bcd_correction_value[BCDC_DATA_W-1:BCDC_NIB_W])
  );

  // ==========================================================================
  // Accumulator and flags
  // ==========================================================================
  logic [BCDC_DATA_W:0] sum_w;
  logic [BCDC_NIB_W:0]  sum_lo;
  logic [BCDC_DATA_W:0] dif_w;
  logic [BCDC_NIB_W:0]  dif_lo;
  logic [BCDC_DATA_W-1:0] opnd;

  always_comb begin
    if (OP_CODE_I == BCDC_OP_ADJ_ADD || OP_CODE_I == BCDC_OP_ADJ_SUB) begin
      opnd = bcd_correction_value;
    end else begin
      opnd = OPERAND_I;
    end
    sum_w  = {1'b0, acc_r} + {1'b0, opnd};
    sum_lo = {1'b0, acc_r[BCDC_NIB_W-1:0]} + {1'b0, opnd[BCDC_NIB_W-1:0]};
    dif_w  = {1'b0, acc_r} - {1'b0, opnd};
    dif_lo = {1'b0, acc_r[BCDC_NIB_W-1:0]} - {1'b0, opnd[BCDC_NIB_W-1:0]};
  end

  always_comb begin
    acc_nxt            = acc_r;
    carry_flag_nxt     = carry_flag_r;
    aux_carry_flag_nxt = aux_carry_flag_r;
    if (OP_VALID_I) begin
      case (OP_CODE_I)
        BCDC_OP_LOAD: begin
          acc_nxt = OPERAND_I;
        end
        BCDC_OP_ADD: begin
          acc_nxt            = sum_w[BCDC_DATA_W-1:0];                        // RULE1
          carry_flag_nxt     = sum_w[BCDC_DATA_W];
          aux_carry_flag_nxt = sum_lo[BCDC_NIB_W];
        end
        BCDC_OP_SUB: begin
          acc_nxt            = dif_w[BCDC_DATA_W-1:0];                        // RULE3
          carry_flag_nxt     = dif_w[BCDC_DATA_W];
          aux_carry_flag_nxt = dif_lo[BCDC_NIB_W];
        end
        BCDC_OP_ADJ_ADD: begin
          // Decimal carry keeps the binary step's carry, or any new one
          acc_nxt            = sum_w[BCDC_DATA_W-1:0];                        // RULE2
          carry_flag_nxt     = carry_flag_r | sum_w[BCDC_DATA_W];             // RULE2
          aux_carry_flag_nxt = sum_lo[BCDC_NIB_W];
        end
        BCDC_OP_ADJ_SUB: begin
          acc_nxt            = dif_w[BCDC_DATA_W-1:0];                        // RULE4
          carry_flag_nxt     = carry_flag_r | dif_w[BCDC_DATA_W];             // RULE4
          aux_carry_flag_nxt = dif_lo[BCDC_NIB_W];
        end
        BCDC_OP_FLAGS: begin
          // Status word restore on interrupt return brings the flags back
          carry_flag_nxt     = OPERAND_I[BCDC_FLAG_CY_BIT];                   // RULE7
          aux_carry_flag_nxt = OPERAND_I[BCDC_FLAG_AC_BIT];
        end
        default: begin
          acc_nxt = acc_r;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_r            <= BCDC_ACC_RST;
      carry_flag_r     <= 1'b0;
      aux_carry_flag_r <= 1'b0;
    end else if (CE_I) begin
      acc_r            <= acc_nxt;
      carry_flag_r     <= carry_flag_nxt;
      aux_carry_flag_r <= aux_carry_flag_nxt;
    end
  end

  assign ACC_O            = acc_r;
  assign CARRY_FLAG_O     = carry_flag_r;
  assign AUX_CARRY_FLAG_O = aux_carry_flag_r;

  // ==========================================================================
  // Read port
  // ==========================================================================
  // Sampled on the strobe cycle only; the last sample is held between reads.
  // Content after reset is meaningless until state has been set.
  logic [BCDC_DATA_W-1:0] rd_data_r;
  logic [BCDC_DATA_W-1:0] rd_data_nxt;
  logic                   rd_valid_r;
  logic                   rd_valid_nxt;

  always_comb begin
    rd_valid_nxt = RD_STB_I;
    rd_data_nxt  = rd_data_r;
    if (RD_STB_I) begin
      rd_data_nxt = bcd_correction_value;                                     // RULE5
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_data_r  <= BCDC_RD_RST;                                              // RULE9
      rd_valid_r <= 1'b0;
    end else if (CE_I) begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign RD_DATA_O  = rd_data_r;
  assign RD_VALID_O = rd_valid_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  function automatic logic [7:0] ref_fix(input logic [7:0] a, input logic cy, input logic ac);
    logic [3:0] hi;
    logic [3:0] lo;
    logic       over;
    over = (a[7:4] == BCDC_NIB_MAX) && (a[3:0] > BCDC_NIB_MAX);
    hi = ((a[7:4] > BCDC_NIB_MAX) || cy || over) ? BCDC_NIB_FIX : BCDC_NIB_ZERO;
    lo = ((a[3:0] > BCDC_NIB_MAX) || ac) ? BCDC_NIB_FIX : BCDC_NIB_ZERO;
    return {hi, lo};
  endfunction

  sequence s_op(bcdc_op_e op);
    CE_I && OP_VALID_I && OP_CODE_I == op;
  endsequence

  sequence s_read_req;
    CE_I && RD_STB_I;
  endsequence

  sequence s_read_ans(logic [7:0] v);
    RD_VALID_O && RD_DATA_O == v;
  endsequence

  a_add_binary: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE1
    s_op(BCDC_OP_ADD) |=> {CARRY_FLAG_O, ACC_O} ==
      9'({1'b0, $past(ACC_O)} + {1'b0, $past(OPERAND_I)}))
    else $error("binary add result wrong");

  a_sub_binary: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE3
    s_op(BCDC_OP_SUB) |=> {CARRY_FLAG_O, ACC_O} ==
      9'({1'b0, $past(ACC_O)} - {1'b0, $past(OPERAND_I)}))
    else $error("binary subtract result wrong");

  a_adj_add_value: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE2
    s_op(BCDC_OP_ADJ_ADD) |=> ACC_O == 8'($past(ACC_O) +
      ref_fix($past(ACC_O), $past(CARRY_FLAG_O), $past(AUX_CARRY_FLAG_O))))
    else $error("adjusting add result wrong");

  a_adj_add_carry: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE2
    s_op(BCDC_OP_ADJ_ADD) ##0 CARRY_FLAG_O |=> CARRY_FLAG_O)
    else $error("decimal carry lost on adjusting add");

  a_adj_sub_value: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE4
    s_op(BCDC_OP_ADJ_SUB) |=> ACC_O == 8'($past(ACC_O) -
      ref_fix($past(ACC_O), $past(CARRY_FLAG_O), $past(AUX_CARRY_FLAG_O))))
    else $error("adjusting subtract result wrong");

  a_read_live_value: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE5
    s_read_req |=> s_read_ans(ref_fix($past(ACC_O), $past(CARRY_FLAG_O),
      $past(AUX_CARRY_FLAG_O))))
    else $error("correction read does not match present state");

  a_fix_nibbles: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE8
    bcd_correction_value == ref_fix(ACC_O, CARRY_FLAG_O, AUX_CARRY_FLAG_O))
    else $error("correction nibbles wrong");

  a_fix_high_over: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE8
    (ACC_O[BCDC_DATA_W-1:BCDC_NIB_W] == BCDC_NIB_MAX) && (ACC_O[BCDC_NIB_W-1:0] > BCDC_NIB_MAX)
      |-> bcd_correction_value == {BCDC_NIB_FIX, BCDC_NIB_FIX})
    else $error("high nibble not fixed above 99");

  a_read_one_pulse: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // RULE9
    s_read_req ##1 CE_I && !RD_STB_I |=> !RD_VALID_O && $stable(RD_DATA_O))
    else $error("read answer not a single pulse");

endmodule

// ---- src/bcdc_nibble_fix.sv ----
`timescale 1ns/1ps
module bcdc_nibble_fix
  import bcdc_pkg::*;
(
  input  wire logic [BCDC_NIB_W-1:0] nib_i,
  input  wire logic                  carry_i,
  output logic      [BCDC_NIB_W-1:0] fix_o
);

  always_comb begin
    if ((nib_i > BCDC_NIB_MAX) || carry_i) begin // RULE8
      fix_o = BCDC_NIB_FIX;
    end else begin
      fix_o = BCDC_NIB_ZERO;
    end
  end

endmodule

// ---- src/bcdc_pkg.sv ----
// How it works
// [RULE1] Binary add of operand lands in accumulator; matching correction becomes readable
// [RULE2] Adjusting add of correction leaves packed BCD in accumulator, decimal carry in flag
// [RULE3] Binary subtract lands in accumulator; matching correction becomes readable
// [RULE4] Adjusting subtract of correction leaves packed BCD and decimal borrow
// [RULE5] Correction read data is computed from present accumulator and flags, never latched; here it is sampled on the strobe and held between reads
// [RULE6] Core must issue the adjusting step directly after the binary step
// [RULE7] Interrupt handlers save accumulator; flags come back with the status word
// [RULE8] Low gets 6 when above 9 or aux carry; high when carry or accumulator above 99
// [RULE9] Correction value is eight bits, read only, undefined after reset
package bcdc_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned BCDC_DATA_W = 8;
  localparam int unsigned BCDC_NIB_W  = 4;

  // ==========================================================================
  // Decimal correction constants
  // ==========================================================================
  localparam logic [3:0] BCDC_NIB_MAX  = 4'h9;
  localparam logic [3:0] BCDC_NIB_FIX  = 4'h6;
  localparam logic [3:0] BCDC_NIB_ZERO = 4'h0;

  // ==========================================================================
  // Flag load layout and reset values
  // ==========================================================================
  localparam int unsigned BCDC_FLAG_CY_BIT = 0;
  localparam int unsigned BCDC_FLAG_AC_BIT = 1;
  localparam logic [7:0]  BCDC_ACC_RST     = 8'h00;
  localparam logic [7:0]  BCDC_RD_RST      = 8'h00;

  // ==========================================================================
  // Core operations
  // ==========================================================================
  typedef enum logic [2:0] {
    BCDC_OP_LOAD,
    BCDC_OP_ADD,
    BCDC_OP_SUB,
    BCDC_OP_ADJ_ADD,
    BCDC_OP_ADJ_SUB,
    BCDC_OP_FLAGS
  } bcdc_op_e;

endpackage

// ---- tb/bcdc_core_tb_top.sv ----
`timescale 1ns/1ps
module bcdc_core_tb_top;
  import bcdc_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       ce_i    = 1'b1;
  logic       op_valid;
  bcdc_op_e   op_code;
  logic [7:0] operand;
  logic       rd_stb;
  logic [7:0] acc;
  logic       cy;
  logic       ac;
  logic [7:0] rd_data;
  logic       rd_valid;
  int         fails        = 0;
  int         total_checks = 0;
  int         cycles       = 0;

  always #2.5 clock_i = ~clock_i;

  bcdc_core dut_u (.CLOCK_I(clock_i), .RST_N_I(rst_n_i), .CE_I(ce_i), .OP_VALID_I(op_valid),
    .OP_CODE_I(op_code), .OPERAND_I(operand), .RD_STB_I(rd_stb), .ACC_O(acc),
    .CARRY_FLAG_O(cy), .AUX_CARRY_FLAG_O(ac), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid));

  bcdc_cpu_model cpu_u (.clk_i(clock_i), .acc_i(acc), .cy_i(cy), .ac_i(ac),
    .op_valid_o(op_valid), .op_code_o(op_code), .operand_o(operand), .rd_stb_o(rd_stb));

  // ==========================================================================
  // Compare and closing
  // ==========================================================================
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Results of an op are seen once the following op has been launched
  task automatic state_chk(input logic [7:0] a, input logic c, input logic h);
    chk8(acc, a);
    chk1(cy, c);
    chk1(ac, h);
  endtask

  task automatic rd_chk(input logic [7:0] e);
    chk1(rd_valid, 1'b1);
    chk8(rd_data, e);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_pair(input logic [7:0] a, b, input logic sub, input logic [7:0] bin,
                        input logic c1, h1, input logic [7:0] fix, res, input logic c2, h2);
    cpu_u.issue(BCDC_OP_LOAD, a, 1'b0);
    cpu_u.issue(sub ? BCDC_OP_SUB : BCDC_OP_ADD, b, 1'b0);
    cpu_u.adjust(sub);
    state_chk(bin, c1, h1);
    cpu_u.idle();
    rd_chk(fix);
    state_chk(res, c2, h2);
  endtask

  task automatic t_live_read();
    cpu_u.issue(BCDC_OP_LOAD, 8'hA5, 1'b0);
    cpu_u.issue(BCDC_OP_FLAGS, 8'h00, 1'b0);
    cpu_u.issue(BCDC_OP_FLAGS, 8'h02, 1'b1);
    cpu_u.issue(BCDC_OP_LOAD, 8'h3C, 1'b1);
    rd_chk(8'h60);
    cpu_u.issue(BCDC_OP_FLAGS, 8'h01, 1'b1);
    rd_chk(8'h66);
    cpu_u.idle();
    rd_chk(8'h06);
    cpu_u.idle();
    chk1(rd_valid, 1'b0);
    chk8(rd_data, 8'h06);
  endtask

  task automatic t_interrupt();
    cpu_u.issue(BCDC_OP_LOAD, 8'h99, 1'b0);
    cpu_u.issue(BCDC_OP_ADD, 8'h89, 1'b0);
    cpu_u.interrupt(8'h47);
    cpu_u.adjust(1'b0);
    state_chk(8'h22, 1'b1, 1'b1);
    cpu_u.idle();
    rd_chk(8'h66);
    state_chk(8'h88, 1'b1, 1'b0);
  endtask

  task automatic t_freeze();
    cpu_u.issue(bcdc_op_e'(3'h6), 8'h55, 1'b0);
    @(posedge clock_i);
    ce_i <= 1'b0;
    cpu_u.issue(BCDC_OP_ADD, 8'h11, 1'b1);
    cpu_u.idle();
    state_chk(8'h88, 1'b1, 1'b0);
    chk1(rd_valid, 1'b0);
    @(posedge clock_i);
    ce_i <= 1'b1;
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_pair(8'h99, 8'h89, 1'b0, 8'h22, 1'b1, 1'b1, 8'h66, 8'h88, 1'b1, 1'b0);
    t_pair(8'h85, 8'h15, 1'b0, 8'h9A, 1'b0, 1'b0, 8'h66, 8'h00, 1'b1, 1'b1);
    t_pair(8'h80, 8'h80, 1'b0, 8'h00, 1'b1, 1'b0, 8'h60, 8'h60, 1'b1, 1'b0);
    t_pair(8'h91, 8'h52, 1'b1, 8'h3F, 1'b0, 1'b1, 8'h06, 8'h39, 1'b0, 1'b0);
    t_live_read();
    t_interrupt();
    t_freeze();
    test_done();
  end
endmodule

// ---- tb/bcdc_cpu_model.sv ----
`timescale 1ns/1ps
module bcdc_cpu_model
  import bcdc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] acc_i,
  input  wire logic       cy_i,
  input  wire logic       ac_i,
  output logic            op_valid_o,
  output bcdc_op_e        op_code_o,
  output logic      [7:0] operand_o,
  output logic            rd_stb_o
);
  // ==========================================================================
  // Instruction issue, one per clock, launched at the rising edge
  // ==========================================================================
  initial begin
    op_valid_o = 1'b0;
    op_code_o  = BCDC_OP_LOAD;
    operand_o  = 8'h00;
    rd_stb_o   = 1'b0;
  end

  task automatic issue(input bcdc_op_e code, input logic [7:0] val, input logic rd);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_code_o  <= code;
    operand_o  <= val;
    rd_stb_o   <= rd;
    @(negedge clk_i);
  endtask

  task automatic idle();
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    rd_stb_o   <= 1'b0;
    // A released operand bus must not look like a held value
    operand_o  <= ~operand_o;
    @(negedge clk_i);
  endtask

  // Adjust step follows the binary step, or the interrupt after it, reading the live value
  task automatic adjust(input logic sub);
    issue(sub ? BCDC_OP_ADJ_SUB : BCDC_OP_ADJ_ADD, ~operand_o, 1'b1);
  endtask

  // ==========================================================================
  // Interrupt in mid-sequence: handler clobbers state, then restores it
  // ==========================================================================
  task automatic interrupt(input logic [7:0] junk);
    logic [7:0] save_acc;
    logic [7:0] save_psw;
    issue(BCDC_OP_LOAD, junk, 1'b0);
    save_acc = acc_i;
    save_psw = {6'h00, ac_i, cy_i};
    issue(BCDC_OP_FLAGS, ~save_psw, 1'b0);
    issue(BCDC_OP_LOAD, save_acc, 1'b0);
    issue(BCDC_OP_FLAGS, save_psw, 1'b0);
  endtask
endmodule
